/* File: dv/isp_host_model.sv */
`timescale 1ns/10ps
// host side of the interrupt line: counts each new request it sees
module isp_host_model (
	input logic clk_sys, // system clock
	input logic rst_b, // async reset, active low
	input logic irq, // level request from the block
	output logic [7:0] irq_rises // rising edges seen so far
);
	logic irq_q; // level at the last edge
	// a level request may stay high for long; only a new rise counts
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_q <= 1'b0;
			irq_rises <= 8'h00;
		end
		else
		begin
			irq_q <= irq;
			if (irq && !irq_q)
				irq_rises <= irq_rises + 8'h01;
		end
	end
endmodule

/* File: dv/tb_isp_irq_cond.sv */
`timescale 1ns/10ps
module tb_isp_irq_cond;
	import isp_pkg::*;
	localparam int DB = 4; // short filter so the run stays brief
	logic clk_sys = 1'b0; // system clock
	logic rst_b = 1'b0; // reset, active low
	logic [7:0] addr = 8'h00; // register address
	logic [15:0] wr_data = 16'h0000; // write data
	logic wr_stb = 1'b0; // write strobe
	logic rd_stb = 1'b0; // read strobe
	logic [15:0] rd_data; // read data
	logic irq; // request to host
	logic [9:0] src = 10'h000; // raw sources, by register bit
	logic [7:0] irq_rises; // requests seen by host
	logic [15:0] got; // last read value
	int n_mismatch = 0;
	int num_checks = 0;

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	isp_irq_cond #(.DB_CYCLES(DB)) DUT (
		.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
		.seq_busy(src[ISP_BIT_SEQ]), .fll_locked(src[ISP_BIT_LOCK]),
		.bias_short(src[ISP_BIT_SHORT]), .bias_detect(src[ISP_BIT_DETECT]),
		.pin1_in(src[ISP_BIT_PIN1]), .pin2_in(src[ISP_BIT_PIN2]),
		.pin3_in(src[ISP_BIT_PIN3]), .pin4_in(src[ISP_BIT_PIN4]),
		.input7_in(src[ISP_BIT_IN7]), .input8_in(src[ISP_BIT_IN8]),
		.irq(irq));
	isp_host_model host (.clk_sys(clk_sys), .rst_b(rst_b), .irq(irq),
		.irq_rises(irq_rises));

	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string what);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t: %s got %h want %h", $time, what, g, e);
		end
	endtask

	// one-cycle write strobe; strobe drops at the next edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe, so sample there
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e,
		input string what);
		@(posedge clk_sys);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		#1 got = rd_data;
		chk(got, e, what);
	endtask

	// let n edges pass, then step off the edge
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic set_src(input logic [9:0] s);
		@(posedge clk_sys);
		src <= s;
	endtask

	task automatic t_reset();
		rdchk(ISP_ADDR_POL, 16'h0000, "sense reset");
		rdchk(ISP_ADDR_DB, 16'h0000, "filter reset");
		rdchk(ISP_ADDR_MASK, {6'h00, ISP_MASK_RST}, "mask reset");
		wr(ISP_ADDR_POL, 16'hffff);
		rdchk(ISP_ADDR_POL, 16'h03ff, "sense width");
		wr(8'h90, 16'hffff);
		rdchk(8'h90, 16'h0000, "unmapped read");
		$display("test reset done");
	endtask

	// sense bit inverts each source alone, both ways
	task automatic apply(input logic [9:0] s, input logic [9:0] p);
		wr(ISP_ADDR_POL, {6'h00, p});
		set_src(s);
		idle(3);
		rdchk(ISP_ADDR_LEVEL, {6'h00, s ^ p}, "conditioned level");
		chk({15'h0000, irq}, 16'h0000, "blocked request");
	endtask

	task automatic t_sense();
		logic [9:0] b;
		for (int i = 0; i < ISP_NSRC; i++)
		begin
			b = 10'h001 << i;
			apply(b, 10'h000);
			apply(10'h000, b);
			apply(b, b);
		end
		$display("test sense done");
	endtask

	task automatic t_irq();
		logic [9:0] p1;
		p1 = 10'h001 << ISP_BIT_PIN1;
		set_src(10'h000);
		wr(ISP_ADDR_POL, 16'h0000);
		wr(ISP_ADDR_STATUS, 16'h03ff);
		rdchk(ISP_ADDR_STATUS, 16'h0000, "flags cleared");
		wr(ISP_ADDR_MASK, 16'h02ff);
		set_src(10'h100);
		idle(2);
		chk({15'h0000, irq}, 16'h0001, "sequencer request");
		set_src(10'h000);
		wr(ISP_ADDR_STATUS, 16'h0100);
		idle(2);
		chk({15'h0000, irq}, 16'h0000, "request cleared");
		// a blocked source flags but never reaches the host
		set_src(p1);
		idle(3);
		chk({15'h0000, irq}, 16'h0000, "pin blocked");
		wr(ISP_ADDR_STATUS, {6'h00, p1});
		rdchk(ISP_ADDR_STATUS, {6'h00, p1}, "set beats clear");
		set_src(10'h000);
		chk({8'h00, irq_rises}, 16'h0001, "host requests");
		$display("test irq done");
	endtask

	task automatic t_debounce();
		wr(ISP_ADDR_MASK, 16'h03ff);
		wr(ISP_ADDR_STATUS, 16'h03ff);
		// bypass: a one-cycle pulse already flags every source
		set_src(10'h3ff);
		set_src(10'h000);
		idle(3);
		rdchk(ISP_ADDR_STATUS, 16'h03ff, "bypass pulse");
		wr(ISP_ADDR_STATUS, 16'h03ff);
		wr(ISP_ADDR_DB, 16'h03ff);
		// one edge short of the hold time must be swallowed
		set_src(10'h3ff);
		repeat (DB - 2) @(posedge clk_sys);
		set_src(10'h000);
		idle(8);
		rdchk(ISP_ADDR_LEVEL, 16'h0000, "short bounce");
		rdchk(ISP_ADDR_STATUS, 16'h0000, "no flag");
		set_src(10'h3ff);
		idle(DB + 4);
		rdchk(ISP_ADDR_LEVEL, 16'h03ff, "held level");
		rdchk(ISP_ADDR_STATUS, 16'h03ff, "held flag");
		set_src(10'h000);
		$display("test debounce done");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// main sequence: hold reset five cycles, then each test in turn
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_sense();
		t_irq();
		t_debounce();
		final_report();
	end

	// the tests need well under 2000 cycles; 20000 means a hang
	initial
	begin
		#200000;
		n_mismatch++;
		$display("BAD %0t: watchdog expired", $time);
		final_report();
	end
endmodule

/* File: rtl/isp_debounce.sv */
`timescale 1ns/10ps
module isp_debounce #(
	parameter int CYCLES = isp_pkg::ISP_DB_CYCLES // hold time in clocks
) (
	input logic clk_sys, // system clock
	input logic rst_b, // async reset, active low
	input logic sig_in, // conditioned source level
	input logic filt_en, // 1 filters, 0 bypasses
	output logic sig_out // filtered level
);
	import isp_pkg::*;

	localparam int CW = $clog2(CYCLES + 1); // counter width
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1); // final count

	// refuse a hold time the counter cannot serve
	if (CYCLES < 1 || CYCLES > 65535)
	begin : g_bad_cycles
		$error("isp_debounce: CYCLES out of range");
	end

	logic stable_q, stable_d; // accepted level
	logic [CW-1:0] cnt_q, cnt_d; // cycles the input has differed

	// accept a new level only after it differs for CYCLES clocks
	always_comb
	begin
		stable_d = stable_q;
		cnt_d = cnt_q;
		if (!filt_en)
		begin
			// bypass keeps tracking, so enabling never glitches
			stable_d = sig_in;
			cnt_d = '0;
		end
		else if (sig_in == stable_q)
			cnt_d = '0; // bounce back restarts the wait
		else if (cnt_q == LAST)
		begin
			stable_d = sig_in;
			cnt_d = '0;
		end
		else
			cnt_d = cnt_q + 1'b1;
	end

	// register only
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stable_q <= 1'b0;
			cnt_q <= '0;
		end
		else
		begin
			stable_q <= stable_d;
			cnt_q <= cnt_d;
		end
	end

	assign sig_out = filt_en ? stable_q : sig_in;

	// a filtered level only moves after the full wait
	a_db_full_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(filt_en && $past(filt_en) && $changed(stable_q))
		|-> ($past(cnt_q) == LAST && $past(sig_in) == stable_q))
		else $error("debounce output moved early");
endmodule

/* File: rtl/isp_irq_cond.sv */
// Our own choice: the strobed register port.
`timescale 1ns/10ps
// Function
// - sense 0: sequencer running asserts source
// - sense 1: sequencer idle asserts source
// - sense 0: loop reaching lock raises source
// - sense 1: loop out of lock raises source
// - bias short sense bit: 0 high, 1 low
// - bias detect sense bit: 0 high, 1 low
// - sequencer source debounced only when enabled
// - bias short debounce enable, resets disabled
// - bias detect debounce enable, resets disabled
// - mask bit 1 blocks source from output
module isp_irq_cond #(
	parameter int DB_CYCLES = isp_pkg::ISP_DB_CYCLES // debounce hold
) (
	input logic clk_sys, // system clock, 100 MHz
	input logic rst_b, // async reset, active low
	input logic [isp_pkg::ISP_AW-1:0] addr, // register address
	input logic [isp_pkg::ISP_DW-1:0] wr_data, // write data
	input logic wr_stb, // write strobe, one cycle
	input logic rd_stb, // read strobe, one cycle
	output logic [isp_pkg::ISP_DW-1:0] rd_data, // read data, next cycle
	input logic seq_busy, // control_write_sequencer running
	input logic fll_locked, // frequency_locked_loop in lock
	input logic bias_short, // microphone_bias short circuit
	input logic bias_detect, // microphone_bias current detect
	input logic pin1_in, // general-purpose pin 1
	input logic pin2_in, // general-purpose pin 2
	input logic pin3_in, // general-purpose pin 3
	input logic pin4_in, // general-purpose pin 4
	input logic input7_in, // general-purpose input 7
	input logic input8_in, // general-purpose input 8
	output logic irq // interrupt to host, active high
);
	import isp_pkg::*;

	// refuse a debounce hold the filters cannot serve
	if (DB_CYCLES < 1 || DB_CYCLES > 65535)
	begin : g_bad_hold
		$error("isp_irq_cond: DB_CYCLES out of range");
	end

	localparam int PAD = ISP_DW - ISP_NSRC; // zero bits above sources

	logic [ISP_NSRC-1:0] raw; // sources as they arrive
	logic [ISP_NSRC-1:0] cond; // after sense inversion
	logic [ISP_NSRC-1:0] filt; // after optional debounce
	logic [ISP_NSRC-1:0] status; // sticky flags
	logic [ISP_NSRC-1:0] clr; // write-one-to-clear pulse
	logic [ISP_NSRC-1:0] sense_q, sense_d; // polarity register
	logic [ISP_NSRC-1:0] filt_en_q, filt_en_d; // debounce register
	logic [ISP_NSRC-1:0] block_q, block_d; // mask register
	logic [ISP_DW-1:0] rd_data_q, rd_data_d; // read answer

	// gather the sources at their register bit positions
	assign raw[ISP_BIT_DETECT] = bias_detect;
	assign raw[ISP_BIT_SHORT] = bias_short;
	assign raw[ISP_BIT_LOCK] = fll_locked;
	assign raw[ISP_BIT_IN7] = input7_in;
	assign raw[ISP_BIT_IN8] = input8_in;
	assign raw[ISP_BIT_PIN1] = pin1_in;
	assign raw[ISP_BIT_PIN2] = pin2_in;
	assign raw[ISP_BIT_PIN3] = pin3_in;
	assign raw[ISP_BIT_SEQ] = seq_busy;
	assign raw[ISP_BIT_PIN4] = pin4_in;

	// configuration writes; unmapped addresses are ignored
	always_comb
	begin
		sense_d = sense_q;
		filt_en_d = filt_en_q;
		block_d = block_q;
		if (wr_stb)
		begin
			case (addr)
				ISP_ADDR_POL: sense_d = wr_data[ISP_NSRC-1:0];
				ISP_ADDR_DB: filt_en_d = wr_data[ISP_NSRC-1:0];
				ISP_ADDR_MASK: block_d = wr_data[ISP_NSRC-1:0];
				default: ; // status clears below, others dropped
			endcase
		end
	end

	// configuration registers; all debounce starts off
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sense_q <= ISP_POL_RST;
			filt_en_q <= ISP_DB_RST;
			block_q <= ISP_MASK_RST;
		end
		else
		begin
			sense_q <= sense_d;
			filt_en_q <= filt_en_d;
			block_q <= block_d;
		end
	end

	// a write to the status register clears the bits given as one
	assign clr = (wr_stb && addr == ISP_ADDR_STATUS) ?
		wr_data[ISP_NSRC-1:0] : '0;

	// per source: invert by the sense bit, then optionally debounce
	for (genvar i = 0; i < ISP_NSRC; i++)
	begin : g_src
		// sense 0 passes the level, 1 inverts it
		assign cond[i] = raw[i] ^ sense_q[i];

		isp_debounce #(
			.CYCLES(DB_CYCLES)
		) u_db (
			.clk_sys(clk_sys),
			.rst_b(rst_b),
			.sig_in(cond[i]),
			.filt_en(filt_en_q[i]),
			.sig_out(filt[i])
		);
	end

	// sticky flags, mask and the single interrupt line
	isp_status u_status (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.level(filt),
		.clr(clr),
		.mask(block_q),
		.status(status),
		.irq(irq)
	);

	// read mux; the answer lives only in the cycle after the strobe
	always_comb
	begin
		rd_data_d = '0;
		if (rd_stb)
		begin
			case (addr)
				ISP_ADDR_STATUS: rd_data_d = {{PAD{1'b0}}, status};
				ISP_ADDR_MASK: rd_data_d = {{PAD{1'b0}}, block_q};
				ISP_ADDR_POL: rd_data_d = {{PAD{1'b0}}, sense_q};
				ISP_ADDR_DB: rd_data_d = {{PAD{1'b0}}, filt_en_q};
				ISP_ADDR_LEVEL: rd_data_d = {{PAD{1'b0}}, filt};
				default: rd_data_d = '0; // unmapped reads as zero
			endcase
		end
	end

	// read data flop
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rd_data_q <= '0;
		else
			rd_data_q <= rd_data_d;
	end

	assign rd_data = rd_data_q;

	// steps of a register access, used by the checks below
	sequence s_wr_db;
		wr_stb && addr == ISP_ADDR_DB;
	endsequence

	sequence s_rd_pol;
		rd_stb && addr == ISP_ADDR_POL;
	endsequence

	sequence s_wr_pol;
		wr_stb && addr == ISP_ADDR_POL;
	endsequence

	sequence s_wr_mask;
		wr_stb && addr == ISP_ADDR_MASK;
	endsequence

	sequence s_rd_status;
		rd_stb && addr == ISP_ADDR_STATUS;
	endsequence

	// busy sequencer with sense 0 and no filter raises its flag
	a_seq_busy_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!sense_q[ISP_BIT_SEQ] && !filt_en_q[ISP_BIT_SEQ] && seq_busy)
		|=> status[ISP_BIT_SEQ])
		else $error("busy sequencer not flagged");

	// idle sequencer with sense 1 and no filter raises its flag
	a_seq_idle_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(sense_q[ISP_BIT_SEQ] && !filt_en_q[ISP_BIT_SEQ] && !seq_busy)
		|=> status[ISP_BIT_SEQ])
		else $error("idle sequencer not flagged");

	// reaching lock with sense 0 raises the lock flag
	a_lock_reach: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!sense_q[ISP_BIT_LOCK] && !filt_en_q[ISP_BIT_LOCK] && fll_locked)
		|=> status[ISP_BIT_LOCK])
		else $error("lock not flagged");

	// losing lock with sense 1 raises the lock flag
	a_lock_lost: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(sense_q[ISP_BIT_LOCK] && !filt_en_q[ISP_BIT_LOCK] && !fll_locked)
		|=> status[ISP_BIT_LOCK])
		else $error("loss of lock not flagged");

	// short input differing from its sense bit sets its flag
	a_short_sense: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!filt_en_q[ISP_BIT_SHORT]
			&& (bias_short != sense_q[ISP_BIT_SHORT]))
		|=> status[ISP_BIT_SHORT])
		else $error("short source sense wrong");

	// detect source with the filter off tracks its sensed input
	a_detect_sense: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!filt_en_q[ISP_BIT_DETECT]
		|-> filt[ISP_BIT_DETECT] == (bias_detect ^ sense_q[ISP_BIT_DETECT]))
		else $error("detect source sense wrong");

	// with the filter on, a change never reaches the filtered level at once
	a_seq_filtered: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(filt_en_q[ISP_BIT_SEQ] && $past(filt_en_q[ISP_BIT_SEQ])
			&& $changed(cond[ISP_BIT_SEQ]))
		|-> !($changed(filt[ISP_BIT_SEQ])
			&& filt[ISP_BIT_SEQ] == cond[ISP_BIT_SEQ]))
		else $error("sequencer filter passed a change");

	// with the short filter off, level passes straight through
	a_short_bypass: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!filt_en_q[ISP_BIT_SHORT]
		|-> filt[ISP_BIT_SHORT] == (bias_short ^ sense_q[ISP_BIT_SHORT]))
		else $error("short bypass not transparent");

	// pin 1 sensed low with sense 1 sets its flag
	a_pin_sense: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(sense_q[ISP_BIT_PIN1] && !filt_en_q[ISP_BIT_PIN1] && !pin1_in)
		|=> status[ISP_BIT_PIN1])
		else $error("pin sense wrong");

	// a debounce write lands in the register on the next edge
	a_db_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_wr_db |=> filt_en_q == $past(wr_data[ISP_NSRC-1:0]))
		else $error("debounce write lost");

	// a read answers one cycle later, then drops back to zero
	a_read_timing: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(s_rd_pol ##1 !rd_stb)
		|-> (rd_data == {{PAD{1'b0}}, $past(sense_q)}) ##1 (rd_data == '0))
		else $error("read answer timing wrong");

	// an unmasked active source drives the line from the next cycle
	a_mask_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		((filt & ~block_q) != '0 && !(wr_stb && addr == ISP_ADDR_MASK))
		|=> irq)
		else $error("mask does not gate interrupt");

	// a write-one clear drops a flag whose source is quiet
	a_clr_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_stb && addr == ISP_ADDR_STATUS && wr_data[ISP_BIT_SEQ]
			&& !filt[ISP_BIT_SEQ])
		|=> !status[ISP_BIT_SEQ])
		else $error("flag not cleared by write");

	// set wins: a clear while the source is active keeps the flag
	a_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_stb && addr == ISP_ADDR_STATUS && wr_data[ISP_BIT_PIN1]
			&& filt[ISP_BIT_PIN1])
		|=> status[ISP_BIT_PIN1])
		else $error("clear beat an active source");

	// a sense write lands in the register on the next edge
	a_pol_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_wr_pol |=> sense_q == $past(wr_data[ISP_NSRC-1:0]))
		else $error("sense write lost");

	// a mask write lands in the register on the next edge
	a_mask_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_wr_mask |=> block_q == $past(wr_data[ISP_NSRC-1:0]))
		else $error("mask write lost");

	// pin 4 sensed low with sense 1 sets its flag
	a_pin4_sense: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(sense_q[ISP_BIT_PIN4] && !filt_en_q[ISP_BIT_PIN4] && !pin4_in)
		|=> status[ISP_BIT_PIN4])
		else $error("pin 4 sense wrong");

	// input 7 high with sense 0 sets its flag
	a_input7_sense: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!sense_q[ISP_BIT_IN7] && !filt_en_q[ISP_BIT_IN7]
			&& input7_in)
		|=> status[ISP_BIT_IN7])
		else $error("input 7 sense wrong");

	// with the lock filter on, a change never shows at once
	a_lock_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(filt_en_q[ISP_BIT_LOCK] && $past(filt_en_q[ISP_BIT_LOCK])
			&& $changed(cond[ISP_BIT_LOCK]))
		|-> !($changed(filt[ISP_BIT_LOCK])
			&& filt[ISP_BIT_LOCK] == cond[ISP_BIT_LOCK]))
		else $error("lock filter passed a change");

	// with the detect filter on, a change never shows at once
	a_detect_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(filt_en_q[ISP_BIT_DETECT] && $past(filt_en_q[ISP_BIT_DETECT])
			&& $changed(cond[ISP_BIT_DETECT]))
		|-> !($changed(filt[ISP_BIT_DETECT])
			&& filt[ISP_BIT_DETECT] == cond[ISP_BIT_DETECT]))
		else $error("detect filter passed a change");

	// pin 2 with its filter off tracks its sensed input
	a_pin_bypass: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!filt_en_q[ISP_BIT_PIN2]
		|-> filt[ISP_BIT_PIN2] == (pin2_in ^ sense_q[ISP_BIT_PIN2]))
		else $error("pin bypass not transparent");

	// read data are zero unless a read strobe came just before
	a_read_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!$past(rd_stb) |-> rd_data == '0)
		else $error("read data stood too long");

	// a status read returns the flags of the strobe cycle
	a_status_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_rd_status |=> rd_data == {{PAD{1'b0}}, $past(status)})
		else $error("status read wrong");

	// with nothing unmasked set or arriving, the line stays low
	a_mask_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
		((status & ~block_q) == '0 && (filt & ~block_q) == '0
			&& !(wr_stb && addr == ISP_ADDR_MASK))
		|=> !irq)
		else $error("blocked flag reached the line");
endmodule

/* File: rtl/isp_pkg.sv */
package isp_pkg;
	// source count and register geometry
	localparam int ISP_NSRC = 10; // conditioned interrupt sources
	localparam int ISP_DW = 16; // register data width
	localparam int ISP_AW = 8; // register address width

	// register addresses
	localparam logic [7:0] ISP_ADDR_STATUS = 8'h7f; // sticky flags, w1c
	localparam logic [7:0] ISP_ADDR_MASK = 8'h80; // 1 blocks a flag
	localparam logic [7:0] ISP_ADDR_POL = 8'h81; // source sense
	localparam logic [7:0] ISP_ADDR_DB = 8'h82; // debounce enables
	localparam logic [7:0] ISP_ADDR_LEVEL = 8'h83; // live conditioned lvl

	// bit position of each source, same in every register
	localparam int ISP_BIT_DETECT = 0; // bias current detect
	localparam int ISP_BIT_SHORT = 1; // bias short circuit
	localparam int ISP_BIT_LOCK = 2; // loop lock
	localparam int ISP_BIT_IN7 = 3; // general-purpose input 7
	localparam int ISP_BIT_IN8 = 4; // general-purpose input 8
	localparam int ISP_BIT_PIN1 = 5; // general-purpose pin 1
	localparam int ISP_BIT_PIN2 = 6; // general-purpose pin 2
	localparam int ISP_BIT_PIN3 = 7; // general-purpose pin 3
	localparam int ISP_BIT_SEQ = 8; // write sequencer activity
	localparam int ISP_BIT_PIN4 = 9; // general-purpose pin 4

	// values after reset
	localparam logic [ISP_NSRC-1:0] ISP_POL_RST = 10'h000;
	localparam logic [ISP_NSRC-1:0] ISP_DB_RST = 10'h000;
	localparam logic [ISP_NSRC-1:0] ISP_MASK_RST = 10'h3ff;
	localparam logic [ISP_NSRC-1:0] ISP_STATUS_RST = 10'h000;

	// debounce time: a least time, so the count rounds up
	localparam int ISP_CLK_MHZ = 100; // clk_sys rate
	localparam int ISP_DB_TIME_NS = 40000; // input must hold this long
	localparam int ISP_DB_CYCLES = (ISP_DB_TIME_NS * ISP_CLK_MHZ + 999) / 1000;
endpackage

/* File: rtl/isp_status.sv */
`timescale 1ns/10ps
module isp_status (
	input logic clk_sys, // system clock
	input logic rst_b, // async reset, active low
	input logic [isp_pkg::ISP_NSRC-1:0] level, // conditioned sources
	input logic [isp_pkg::ISP_NSRC-1:0] clr, // w1c pulse per bit
	input logic [isp_pkg::ISP_NSRC-1:0] mask, // 1 blocks a bit
	output logic [isp_pkg::ISP_NSRC-1:0] status, // sticky flags
	output logic irq // level, high while unmasked flag set
);
	import isp_pkg::*;

	logic [ISP_NSRC-1:0] status_q, status_d; // sticky flags

	// set wins over clear: an event in the clear cycle is kept
	always_comb
	begin
		status_d = (status_q & ~clr) | level;
	end

	// register only
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			status_q <= ISP_STATUS_RST;
		else
			status_q <= status_d;
	end

	assign status = status_q;
	assign irq = |(status_q & ~mask);

	// a flag once set stays until written with a one
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
		($past(status_q[0]) && !$past(clr[0])) |-> status_q[0])
		else $error("flag dropped without clear");
endmodule
